/* File: hw/status_bank_pkg.sv */
// Constants and types shared by the status and bank select logic
package status_bank_pkg;

    // Nibble addresses of the status word in data memory
    localparam logic [11:0] STATUS_LO_ADDR = 12'hfb0;
    localparam logic [11:0] STATUS_HI_ADDR = 12'hfb1;

    // Bit positions within the 8-bit status word
    localparam int SW_CARRY_BIT  = 7;
    localparam int SW_SKIP_LSB   = 4;
    localparam int SW_IST_LSB    = 2;
    localparam int SW_MBE_BIT    = 1;
    localparam int SW_RBE_BIT    = 0;

    // Bit positions within the low status nibble
    localparam int LO_IST_LSB    = 2;
    localparam int LO_MBE_BIT    = 1;
    localparam int LO_RBE_BIT    = 0;

    // Enable bits in program word 0 and in each vector entry
    localparam int ROM_MBE_BIT   = 7;
    localparam int ROM_RBE_BIT   = 6;

    // Bit positions within the 8-bit bank select word
    localparam int BS_MBS_LSB    = 4;
    localparam int BS_RBS_LSB    = 0;

    // Values after reset
    localparam logic [3:0] MBS_RESET   = 4'h0;
    localparam logic [1:0] RBS_RESET   = 2'h0;
    localparam logic [2:0] SKIP_RESET  = 3'h0;
    localparam logic       CARRY_RESET = 1'b0;

    // Memory bank numbers that may be selected
    localparam logic [3:0] MB_LAST_LOW = 4'h3;
    localparam logic [3:0] MB_IO_BANK  = 4'hf;

    // Fixed address space split when the memory bank is off
    localparam logic [7:0] FIXED_SPLIT = 8'h80;
    localparam logic [3:0] FIXED_LOW   = 4'h0;
    localparam logic [3:0] FIXED_HIGH  = 4'hf;

    localparam logic [1:0] REG_BANK0   = 2'h0;

    // Interrupt nesting status
    typedef enum logic [1:0] {
        STATUS0 = 2'b00,
        STATUS1 = 2'b01,
        STATUS2 = 2'b10
    } ist_t;

    localparam logic [1:0] IST_FORBIDDEN = 2'b11;

endpackage : status_bank_pkg

/* File: hw/bank_if.sv */
// Bank state and address results between core and address generator
`timescale 1ns/100ps
interface bank_if (
    input wire logic clk,
    input wire logic srst
);
    logic        membank_enable;
    logic        regbank_enable;
    logic [3:0]  membank_field;
    logic [1:0]  regbank_field;
    logic [7:0]  offset;
    logic [11:0] data_addr;
    logic [1:0]  reg_bank;

    modport core (
        output membank_enable, regbank_enable, membank_field,
        output regbank_field, offset,
        input  data_addr, reg_bank, clk, srst
    );
    modport gen (
        input  membank_enable, regbank_enable, membank_field,
        input  regbank_field, offset, clk, srst,
        output data_addr, reg_bank
    );
endinterface : bank_if

/* File: hw/bank_addr_gen.sv */
// Data address and register bank generation from bank state
`timescale 1ns/100ps
module bank_addr_gen (
    bank_if.gen bi
);
    logic [3:0] hi_nib;

    always_comb begin
        if (bi.membank_enable) begin
            hi_nib = bi.membank_field;
        end else if (bi.offset < status_bank_pkg::FIXED_SPLIT) begin
            hi_nib = status_bank_pkg::FIXED_LOW;
        end else begin
            hi_nib = status_bank_pkg::FIXED_HIGH;
        end
    end

    assign bi.data_addr = {hi_nib, bi.offset};
    assign bi.reg_bank  = bi.regbank_enable ? bi.regbank_field
                        : status_bank_pkg::REG_BANK0;

    default clocking cb @(posedge bi.clk); endclocking
    default disable iff (bi.srst);

    chk_addr_bank_on: assert property (
        bi.membank_enable |->
            bi.data_addr[11:8] == bi.membank_field)
        else $error("bank field not used as high address");

    chk_addr_bank_off: assert property (
        !bi.membank_enable && $changed(bi.membank_field) &&
        $stable(bi.offset) |-> $stable(bi.data_addr))
        else $error("bank field leaked into fixed space");

    chk_regbank_sel: assert property (
        bi.regbank_enable |-> bi.reg_bank == bi.regbank_field)
        else $error("register bank not taken from field");

    chk_regbank_zero: assert property (
        !bi.regbank_enable |-> bi.reg_bank == 2'h0)
        else $error("register bank not zero when disabled");

endmodule : bank_addr_gen

/* File: hw/status_bank.sv */
// Status word, interrupt status, bank enables and bank select register
`timescale 1ns/100ps
//
// Contract
// - Skip flags set by execution, never by operand
// - Status codes 00, 01, 10; 11 never held
// - Interrupt accept pushes status, steps level up
// - Return from interrupt restores prior status level
// - Status level read and written as memory
// - Memory bank on: field gives high address nibble
// - Memory bank off: fixed space, field ignored
// - Reset loads memory bank enable from bit 7
// - Vector entry bit 7 loads memory bank enable
// - Register bank on: field picks bank
// - Register bank off: bank zero always
// - Reset loads register bank enable from bit 6
// - Vector entry bit 6 loads register bank enable
// - Each bank field set by own select instruction
// - Bank select pushed and popped as byte; a pop with an illegal memory bank keeps the old memory bank field
// - Memory bank field four bits, banks 0-3,15
// - Reset clears memory bank field
// - Reset clears register bank field
// - Register bank upper two bits read zero
// - Status word at two nibble addresses
// - Interrupt saves all; calls save enables only
module status_bank (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  rom_word0,
    input  wire logic        skip_load,
    input  wire logic [2:0]  skip_value,
    input  wire logic        carry_load,
    input  wire logic        carry_value,
    input  wire logic        irq_accept,
    input  wire logic [7:0]  vector_word,
    input  wire logic        return_from_irq_exec,
    input  wire logic        ret_exec,
    input  wire logic [7:0]  restore_word,
    input  wire logic [11:0] mem_addr,
    input  wire logic        mem_wr,
    input  wire logic [3:0]  mem_wdata,
    input  wire logic        mem_rd,
    output logic      [3:0]  mem_rdata,
    output logic             mem_rvalid,
    input  wire logic        sel_regbank_instr,
    input  wire logic        sel_membank_instr,
    input  wire logic [3:0]  bank_imm,
    input  wire logic        pop_bank_select,
    input  wire logic [7:0]  pop_data,
    output logic      [7:0]  status_word,
    output logic      [7:0]  bank_select_reg,
    input  wire logic [7:0]  op_offset,
    output logic      [11:0] data_addr,
    output logic      [1:0]  reg_bank
);
    logic                   carry_r;
    logic [2:0]             skip_r;
    status_bank_pkg::ist_t  ist_r;
    logic                   mbe_r;
    logic                   rbe_r;
    logic [3:0]             mbs_r;
    logic [1:0]             rbs_r;
    logic [3:0]             rdata_r;
    logic                   rvalid_r;
    logic                   wr_lo;
    logic                   pop_ok;

    function automatic logic mb_legal(input logic [3:0] v);
        mb_legal = (v <= status_bank_pkg::MB_LAST_LOW) ||
                   (v == status_bank_pkg::MB_IO_BANK);
    endfunction : mb_legal

    function automatic status_bank_pkg::ist_t ist_step(
        input status_bank_pkg::ist_t cur);
        unique case (cur)
            status_bank_pkg::STATUS0: ist_step = status_bank_pkg::STATUS1;
            status_bank_pkg::STATUS1: ist_step = status_bank_pkg::STATUS2;
            status_bank_pkg::STATUS2: ist_step = status_bank_pkg::STATUS2;
            default:                  ist_step = status_bank_pkg::STATUS2;
        endcase
    endfunction : ist_step

    // Only the low nibble is writable; the high one holds carry and skips
    assign wr_lo  = mem_wr && (mem_addr == status_bank_pkg::STATUS_LO_ADDR);
    assign pop_ok = mb_legal(pop_data[7:4]);

    // Carry, kept here so the status word is complete
    always_ff @(posedge clk) begin
        if (srst) begin
            carry_r <= status_bank_pkg::CARRY_RESET;
        end else if (return_from_irq_exec) begin
            carry_r <= restore_word[status_bank_pkg::SW_CARRY_BIT];
        end else if (carry_load) begin
            carry_r <= carry_value;
        end
    end

    // Skip flags follow execution only
    always_ff @(posedge clk) begin
        if (srst) begin
            skip_r <= status_bank_pkg::SKIP_RESET;
        end else if (return_from_irq_exec) begin
            skip_r <= restore_word[status_bank_pkg::SW_SKIP_LSB +: 3];
        end else if (skip_load) begin
            skip_r <= skip_value;
        end
    end

    // Interrupt nesting level
    always_ff @(posedge clk) begin
        if (srst) begin
            ist_r <= status_bank_pkg::STATUS0;
        end else if (irq_accept) begin
            ist_r <= ist_step(ist_r);
        end else if (return_from_irq_exec) begin
            if (restore_word[status_bank_pkg::SW_IST_LSB +: 2] !=
                status_bank_pkg::IST_FORBIDDEN) begin
                ist_r <= status_bank_pkg::ist_t'(
                    restore_word[status_bank_pkg::SW_IST_LSB +: 2]);
            end
        end else if (wr_lo) begin
            if (mem_wdata[status_bank_pkg::LO_IST_LSB +: 2] !=
                status_bank_pkg::IST_FORBIDDEN) begin
                ist_r <= status_bank_pkg::ist_t'(
                    mem_wdata[status_bank_pkg::LO_IST_LSB +: 2]);
            end
        end
    end

    // Bank enables, loaded from program word 0 during reset
    always_ff @(posedge clk) begin
        if (srst) begin
            mbe_r <= rom_word0[status_bank_pkg::ROM_MBE_BIT];
            rbe_r <= rom_word0[status_bank_pkg::ROM_RBE_BIT];
        end else if (irq_accept) begin
            mbe_r <= vector_word[status_bank_pkg::ROM_MBE_BIT];
            rbe_r <= vector_word[status_bank_pkg::ROM_RBE_BIT];
        end else if (return_from_irq_exec || ret_exec) begin
            mbe_r <= restore_word[status_bank_pkg::SW_MBE_BIT];
            rbe_r <= restore_word[status_bank_pkg::SW_RBE_BIT];
        end else if (wr_lo) begin
            mbe_r <= mem_wdata[status_bank_pkg::LO_MBE_BIT];
            rbe_r <= mem_wdata[status_bank_pkg::LO_RBE_BIT];
        end
    end

    // Memory bank field; illegal bank numbers leave it unchanged
    always_ff @(posedge clk) begin
        if (srst) begin
            mbs_r <= status_bank_pkg::MBS_RESET;
        end else if (pop_bank_select) begin
            if (pop_ok) begin
                mbs_r <= pop_data[status_bank_pkg::BS_MBS_LSB +: 4];
            end
        end else if (sel_membank_instr && mb_legal(bank_imm)) begin
            mbs_r <= bank_imm;
        end
    end

    // Register bank field, two bits stored
    always_ff @(posedge clk) begin
        if (srst) begin
            rbs_r <= status_bank_pkg::RBS_RESET;
        end else if (pop_bank_select) begin
            rbs_r <= pop_data[status_bank_pkg::BS_RBS_LSB +: 2];
        end else if (sel_regbank_instr) begin
            rbs_r <= bank_imm[1:0];
        end
    end

    // Memory read of the status nibbles, one cycle later
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r  <= 4'h0;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= mem_rd;
            if (mem_addr == status_bank_pkg::STATUS_LO_ADDR) begin
                rdata_r <= status_word[3:0];
            end else if (mem_addr == status_bank_pkg::STATUS_HI_ADDR) begin
                rdata_r <= status_word[7:4];
            end else begin
                rdata_r <= 4'h0;
            end
        end
    end

    assign status_word     = {carry_r, skip_r, ist_r, mbe_r, rbe_r};
    assign bank_select_reg = {mbs_r, 2'b00, rbs_r};
    assign mem_rdata       = rdata_r;
    assign mem_rvalid      = rvalid_r;

    bank_if bif (
        .clk  (clk),
        .srst (srst)
    );

    assign bif.membank_enable = mbe_r;
    assign bif.regbank_enable = rbe_r;
    assign bif.membank_field  = mbs_r;
    assign bif.regbank_field  = rbs_r;
    assign bif.offset         = op_offset;
    assign data_addr          = bif.data_addr;
    assign reg_bank           = bif.reg_bank;

    bank_addr_gen u_gen (
        .bi (bif.gen)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence seq_irq_taken;
        irq_accept && ist_r == status_bank_pkg::STATUS0;
    endsequence

    sequence seq_pop_legal;
        pop_bank_select && mb_legal(pop_data[7:4]);
    endsequence

    chk_skip_update: assert property (
        skip_load && !return_from_irq_exec |=> skip_r == $past(skip_value))
        else $error("skip flags not updated");

    chk_skip_no_write: assert property (
        mem_wr && mem_addr == status_bank_pkg::STATUS_HI_ADDR &&
        !skip_load && !return_from_irq_exec |=> $stable(skip_r))
        else $error("skip flags changed by a memory write");

    chk_ist_legal: assert property (
        ist_r != status_bank_pkg::IST_FORBIDDEN)
        else $error("interrupt status holds forbidden code");

    chk_irq_step: assert property (
        seq_irq_taken |=> ist_r == status_bank_pkg::STATUS1 &&
            mbe_r == $past(vector_word[7]) &&
            rbe_r == $past(vector_word[6]))
        else $error("interrupt accept did not step or load enables");

    chk_return_from_irq_all: assert property (
        return_from_irq_exec && !irq_accept &&
        restore_word[3:2] != 2'b11 |=> status_word == $past(restore_word))
        else $error("return from interrupt did not restore status");

    chk_ret_enables: assert property (
        ret_exec && !return_from_irq_exec && !irq_accept |=>
            $stable(ist_r) && mbe_r == $past(restore_word[1]) &&
            rbe_r == $past(restore_word[0]))
        else $error("plain return touched more than enables");

    chk_ist_write: assert property (
        wr_lo && !irq_accept && !return_from_irq_exec && mem_wdata[3:2] != 2'b11
        ##1 !mem_wr && !irq_accept && !return_from_irq_exec
        ##1 mem_rd && mem_addr == status_bank_pkg::STATUS_LO_ADDR &&
            !irq_accept && !return_from_irq_exec
        |=> mem_rvalid && mem_rdata[3:2] == $past(mem_wdata[3:2], 3))
        else $error("status level write not read back");

    chk_pop_byte: assert property (
        seq_pop_legal |=> bank_select_reg ==
            {$past(pop_data[7:4]), 2'b00, $past(pop_data[1:0])})
        else $error("bank select pop not taken as a byte");

    chk_mb_legal: assert property (
        mbs_r <= 4'h3 || mbs_r == 4'hf)
        else $error("memory bank field holds an illegal bank");

    chk_reset_load: assert property (
        @(posedge clk) disable iff (1'b0)
        srst |=> mbe_r == $past(rom_word0[7]) &&
            rbe_r == $past(rom_word0[6]) &&
            mbs_r == 4'h0 && rbs_r == 2'h0)
        else $error("reset did not load enables or clear banks");

    // Select instructions that no pop overrides
    sequence seq_sel_mb_legal;
        sel_membank_instr && !pop_bank_select &&
        (bank_imm <= 4'h3 || bank_imm == 4'hf);
    endsequence

    sequence seq_pop_illegal;
        pop_bank_select &&
        pop_data[7:4] > 4'h3 && pop_data[7:4] != 4'hf;
    endsequence

    chk_sel_mb_take: assert property (
        seq_sel_mb_legal |=> mbs_r == $past(bank_imm))
        else $error("memory bank select not taken");

    chk_sel_rb_take: assert property (
        sel_regbank_instr && !pop_bank_select |=>
            rbs_r == $past(bank_imm[1:0]))
        else $error("register bank select not taken");

    chk_pop_refuse: assert property (
        seq_pop_illegal |=> $stable(mbs_r) &&
            rbs_r == $past(pop_data[1:0]))
        else $error("illegal memory bank taken from pop");

    chk_read_hi: assert property (
        mem_rd && mem_addr == status_bank_pkg::STATUS_HI_ADDR |=>
            mem_rvalid && mem_rdata == $past(status_word[7:4]))
        else $error("high status nibble not read back");

    chk_irq_nest: assert property (
        irq_accept && ist_r == status_bank_pkg::STATUS1 |=>
            ist_r == status_bank_pkg::STATUS2)
        else $error("nested interrupt did not step status");

endmodule : status_bank

/* File: dv/seq_stack_model.sv */
// Sequencer stack model: saves and returns status words
`timescale 1ns/100ps
module seq_stack_model (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       irq_accept,
    input  wire logic       call_exec,
    input  wire logic       return_from_irq_exec,
    input  wire logic       ret_exec,
    input  wire logic [7:0] status_word,
    output logic      [7:0] restore_word
);
    logic [7:0] stack_r [0:7];
    logic [2:0] sp_r;

    // Interrupt saves the whole word; a call saves the enables and inverts the rest
    always_ff @(posedge clk) begin
        if (srst) begin
            sp_r <= 3'h0;
        end else if (irq_accept || call_exec) begin
            stack_r[sp_r] <= irq_accept ? status_word
                : {~status_word[7:2], status_word[1:0]};
            sp_r          <= sp_r + 3'h1;
        end else if (return_from_irq_exec || ret_exec) begin
            sp_r <= sp_r - 3'h1;
        end
    end

    assign restore_word = stack_r[sp_r - 3'h1];
endmodule : seq_stack_model

/* File: dv/status_flags_bank_select_test.sv */
// Self-checking bench for the status word and bank select block
`timescale 1ns/100ps
module status_flags_bank_select_test;
    logic        clk, srst, skip_load, carry_load, carry_value;
    logic        irq_accept, return_from_irq_exec, ret_exec, call_exec, mem_wr;
    logic        mem_rd, mem_rvalid, sel_regbank_instr;
    logic        sel_membank_instr, pop_bank_select;
    logic [2:0]  skip_value;
    logic [1:0]  reg_bank;
    logic [3:0]  mem_wdata, mem_rdata, bank_imm, exp_mbs;
    logic [7:0]  rom_word0, vector_word, restore_word, pop_data;
    logic [7:0]  status_word, bank_select_reg, op_offset;
    logic [11:0] mem_addr, data_addr;
    int          num_errors, checked;

    status_bank u_dut (.clk(clk), .srst(srst), .rom_word0(rom_word0),
        .skip_load(skip_load), .skip_value(skip_value),
        .carry_load(carry_load), .carry_value(carry_value),
        .irq_accept(irq_accept), .vector_word(vector_word),
        .return_from_irq_exec(return_from_irq_exec), .ret_exec(ret_exec),
        .restore_word(restore_word), .mem_addr(mem_addr),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
        .sel_regbank_instr(sel_regbank_instr),
        .sel_membank_instr(sel_membank_instr), .bank_imm(bank_imm),
        .pop_bank_select(pop_bank_select), .pop_data(pop_data),
        .status_word(status_word), .bank_select_reg(bank_select_reg),
        .op_offset(op_offset), .data_addr(data_addr),
        .reg_bank(reg_bank));

    seq_stack_model u_stack (.clk(clk), .srst(srst),
        .irq_accept(irq_accept), .call_exec(call_exec),
        .return_from_irq_exec(return_from_irq_exec), .ret_exec(ret_exec),
        .status_word(status_word), .restore_word(restore_word));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string what, input logic [11:0] exp,
                       input logic [11:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Ends every strobe raised at the last falling edge, then idles
    // one cycle so that no strobe is driven twice in one time step
    task automatic tick();
        @(negedge clk);
        {skip_load, carry_load, irq_accept, return_from_irq_exec, ret_exec} = '0;
        {call_exec, sel_regbank_instr, sel_membank_instr} = '0;
        {pop_bank_select, mem_wr, mem_rd} = '0;
        @(negedge clk);
    endtask : tick

    task automatic mem_write(input logic [11:0] a, input logic [3:0] d);
        mem_addr  = a;
        mem_wdata = d;
        mem_wr    = 1'b1;
        tick();
    endtask : mem_write

    task automatic mem_read(input logic [11:0] a, input logic [3:0] e);
        mem_addr = a;
        mem_rd   = 1'b1;
        @(negedge clk);
        mem_rd = 1'b0;
        chk("mem_rvalid", 12'h001, {11'h0, mem_rvalid});
        chk("mem_rdata", {8'h00, e}, {8'h00, mem_rdata});
        @(negedge clk);
    endtask : mem_read

    task automatic conclude();
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        conclude();
    end

    initial begin
        num_errors = 0;
        checked    = 0;
        srst = 1'b1;
        rom_word0 = 8'hc0;
        {skip_load, carry_load, irq_accept, return_from_irq_exec, ret_exec} = '0;
        {call_exec, sel_regbank_instr, sel_membank_instr} = '0;
        {pop_bank_select, mem_wr, mem_rd, carry_value} = '0;
        {skip_value, bank_imm, mem_wdata, mem_addr} = '0;
        {vector_word, pop_data, op_offset} = '0;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        chk("status_word", 12'h003, {4'h0, status_word});
        chk("bank_select", 12'h000, {4'h0, bank_select_reg});
        skip_value  = 3'h5;
        skip_load   = 1'b1;
        carry_value = 1'b1;
        carry_load  = 1'b1;
        tick();
        chk("status_word", 12'h0d3, {4'h0, status_word});
        mem_write(12'hfb1, 4'h0);
        chk("status_word", 12'h0d3, {4'h0, status_word});
        mem_write(12'hfb0, 4'h5);
        mem_read(12'hfb0, 4'h5);
        mem_read(12'hfb1, 4'hd);
        mem_read(12'h123, 4'h0);
        mem_write(12'hfb0, 4'hc);
        chk("status_word", 12'h0d4, {4'h0, status_word});
        vector_word = 8'hc0;
        irq_accept  = 1'b1;
        tick();
        chk("status_word", 12'h0db, {4'h0, status_word});
        vector_word = 8'h40;
        irq_accept  = 1'b1;
        tick();
        chk("status_word", 12'h0d9, {4'h0, status_word});
        skip_value = 3'h0;
        skip_load  = 1'b1;
        tick();
        return_from_irq_exec = 1'b1;
        tick();
        chk("status_word", 12'h0db, {4'h0, status_word});
        return_from_irq_exec = 1'b1;
        tick();
        chk("status_word", 12'h0d4, {4'h0, status_word});
        call_exec = 1'b1;
        tick();
        mem_write(12'hfb0, 4'h7);
        ret_exec = 1'b1;
        tick();
        chk("status_word", 12'h0d4, {4'h0, status_word});
        exp_mbs = 4'h0;
        for (int i = 0; i < 16; i++) begin
            bank_imm          = 4'(i);
            sel_membank_instr = 1'b1;
            tick();
            if (i <= 3 || i == 15) begin
                exp_mbs = 4'(i);
            end
            chk("mbs", {8'h00, exp_mbs},
                {8'h00, bank_select_reg[7:4]});
        end
        for (int i = 0; i < 4; i++) begin
            bank_imm          = {2'b11, 2'(i)};
            sel_regbank_instr = 1'b1;
            tick();
            chk("bank_select", {4'h0, 4'hf, 2'b00, 2'(i)},
                {4'h0, bank_select_reg});
        end
        pop_data        = 8'h2e;
        pop_bank_select = 1'b1;
        tick();
        chk("bank_select", 12'h022, {4'h0, bank_select_reg});
        pop_data        = 8'h51;
        pop_bank_select = 1'b1;
        tick();
        chk("bank_select", 12'h021, {4'h0, bank_select_reg});
        op_offset = 8'h34;
        mem_write(12'hfb0, 4'h3);
        chk("data_addr", 12'h234, data_addr);
        chk("reg_bank", 12'h001, {10'h0, reg_bank});
        mem_write(12'hfb0, 4'h0);
        chk("data_addr", 12'h034, data_addr);
        op_offset = 8'h95;
        #1;
        chk("data_addr", 12'hf95, data_addr);
        chk("reg_bank", 12'h000, {10'h0, reg_bank});
        bank_imm          = 4'h1;
        sel_membank_instr = 1'b1;
        tick();
        chk("data_addr", 12'hf95, data_addr);
        chk("mbs", 12'h001, {8'h00, bank_select_reg[7:4]});
        srst      = 1'b1;
        rom_word0 = 8'h40;
        tick();
        srst = 1'b0;
        chk("status_word", 12'h001, {4'h0, status_word});
        chk("bank_select", 12'h000, {4'h0, bank_select_reg});
        vector_word = 8'h80;
        irq_accept  = 1'b1;
        tick();
        chk("status_word", 12'h006, {4'h0, status_word});
        conclude();
    end
endmodule : status_flags_bank_select_test
